// ### core/lmsu_line_state_update.sv
// MESI line-state update for processor read and write cycles mastered by the cache
`timescale 1ns/1ps
module lmsu_line_state_update
  import lmsu_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [SECTOR_INDEX_W-1:0] reqIndex,
  input wire logic reqLine,
  input wire logic reqData,
  input wire logic reqLock,
  input wire logic splitAccess,
  input wire logic pageWritethrough,
  input wire logic pageUncacheable,
  input wire logic membusCacheable,
  input wire logic memDone,
  input wire logic membusWritebackNWt,
  input wire logic membusReadonly,
  input wire logic directToModified,
  output logic reqReady,
  output logic respValid,
  output logic cpuCacheAllow,
  output logic cpuWritebackSelect,
  output logic sramUpdate,
  output logic dataFromArray,
  output logic readThroughCycle,
  output logic writeThroughCycle,
  output logic lineFillCycle,
  output logic normalReadCycle,
  output logic writeAllocateFill,
  output logic [1:0] lineStateOut,
  output logic tagReadonlyOut
);
  // Fill destination: read-only wins over every other attribute
  function automatic lmsu_mesi_type fill_state(
    input logic readOnly,
    input logic writeThrough,
    input logic toModified
  );
    lmsu_mesi_type st;
    if (readOnly) begin
      st = MESI_S;
    end else if (writeThrough) begin
      st = MESI_S;
    end else if (toModified) begin
      st = MESI_M;
    end else begin
      st = MESI_E;
    end
    return st;
  endfunction

  function automatic lmsu_plan_type plan_request(
    input logic isWrite,
    input lmsu_mesi_type st,
    input logic tag_readonly_bit,
    input logic lock,
    input logic split,
    input logic page_writethrough,
    input logic page_uncacheable,
    input logic membus_cacheable
  );
    lmsu_plan_type p;
    logic ls;
    p.cycle = CYC_NONE;
    p.nextState = st;
    p.cacheAllow = 1'b1;
    p.writeback = 1'b0;
    p.sramUpdate = 1'b0;
    p.fromArray = 1'b0;
    p.finalAtDone = 1'b0;
    ls = lock & split;
    if (!isWrite) begin
      case (st)
        MESI_M: begin
          if (ls) begin
            p.cycle = CYC_READ_THROUGH_CYCLE;
            p.cacheAllow = 1'b0;
            p.fromArray = 1'b1;
          end else begin
            p.writeback = 1'b1;
          end
        end
        MESI_E: begin
          if (ls) begin
            p.cycle = CYC_READ_THROUGH_CYCLE;
            p.cacheAllow = 1'b0;
          end
        end
        MESI_S: begin
          if (lock) begin
            p.cycle = CYC_READ_THROUGH_CYCLE;
            p.cacheAllow = 1'b0;
          end else begin
            p.nextState = MESI_S;
          end
        end
        MESI_I: begin
          if (page_uncacheable || !membus_cacheable || ls) begin
            p.cycle = CYC_NORMAL_READ_CYCLE;
            p.cacheAllow = 1'b0;
          end else begin
            p.cycle = CYC_LINE_FILL_CYCLE;
            p.finalAtDone = 1'b1;
          end
        end
        default: begin
          p.nextState = MESI_I;
        end
      endcase
    end else begin
      case (st)
        MESI_M: begin
          p.sramUpdate = 1'b1;
          p.writeback = 1'b1;
          if (ls) begin
            p.cycle = CYC_WRITE_THROUGH_CYCLE;
          end
        end
        MESI_E: begin
          p.sramUpdate = 1'b1;
          if (ls) begin
            p.cycle = CYC_WRITE_THROUGH_CYCLE;
          end else begin
            p.nextState = MESI_M;
            p.writeback = 1'b1;
          end
        end
        MESI_S: begin
          p.cycle = CYC_WRITE_THROUGH_CYCLE;
          if (tag_readonly_bit) begin
            p.sramUpdate = 1'b0;
          end else if (page_writethrough || ls) begin
            p.sramUpdate = 1'b1;
          end else begin
            p.sramUpdate = 1'b1;
            p.finalAtDone = 1'b1;
          end
        end
        MESI_I: begin
          if (page_uncacheable || !membus_cacheable || page_writethrough || lock) begin
            p.cycle = CYC_WRITE_THROUGH_CYCLE;
          end else begin
            p.cycle = CYC_WRITE_THROUGH_CYCLE_WRITE_ALLOCATE_FILL;
            p.finalAtDone = 1'b1;
          end
        end
        default: begin
          p.nextState = MESI_I;
        end
      endcase
    end
    return p;
  endfunction

  lmsu_mesi_type curState;
  logic curTro;
  lmsu_plan_type plan;
  logic accept;
  logic memWriteThrough;

  lmsu_fsm_type fsm_q;
  lmsu_plan_type heldPlan_q;
  logic [SECTOR_INDEX_W-1:0] heldIndex_q;
  logic heldTro_q, heldLine_q, heldData_q, heldPwt_q;

  logic storeWrite, troWrite, troValue, finishMem, finishAlloc;
  lmsu_mesi_type storeState;

  logic reqReady_q, respValid_q, cpuCacheAllow_q, cpuWritebackSelect_q, sramUpdate_q;
  logic dataFromArray_q, readThroughCycle_q, writeThroughCycle_q, lineFillCycle_q;
  logic normalReadCycle_q, writeAllocateFill_q, tagReadonlyOut_q;
  logic [1:0] lineStateOut_q;

  lmsu_sector_store store (
    .clock(clock),
    .resetn(resetn),
    .rdIndex(reqIndex),
    .rdLine(reqLine),
    .rdState(curState),
    .rdTro(curTro),
    .wrEnable(storeWrite),
    .wrIndex(storeWrite && fsm_q == FSM_IDLE ? reqIndex : heldIndex_q),
    .wrLine(storeWrite && fsm_q == FSM_IDLE ? reqLine : heldLine_q),
    .wrState(storeState),
    .troWrEnable(troWrite),
    .troValue(troValue)
  );

  assign accept = reqValid & reqReady_q & (fsm_q == FSM_IDLE);
  assign memWriteThrough = ~membusWritebackNWt;
  assign finishMem = (fsm_q == FSM_MEM) & memDone & (heldPlan_q.cycle != CYC_WRITE_THROUGH_CYCLE_WRITE_ALLOCATE_FILL);
  assign finishAlloc = (fsm_q == FSM_WRITE_ALLOCATE_FILL) & memDone;

  always_comb begin
    plan = plan_request(reqWrite, curState, curTro, reqLock, splitAccess,
                        pageWritethrough, pageUncacheable, membusCacheable);
  end

  // Final line state and tag-bit writes; fill attributes are taken at memDone
  always_comb begin
    storeWrite = 1'b0;
    storeState = MESI_I;
    troWrite = 1'b0;
    troValue = TRO_RESET;
    if (accept && plan.cycle == CYC_NONE) begin
      storeWrite = 1'b1;
      storeState = plan.nextState;
    end else if (finishMem) begin
      storeWrite = 1'b1;
      storeState = heldPlan_q.nextState;
      if (heldPlan_q.cycle == CYC_LINE_FILL_CYCLE) begin
        storeState = fill_state(membusReadonly, heldPwt_q | memWriteThrough,
                                directToModified);
        troWrite = 1'b1;
        troValue = membusReadonly;
      end else if (heldPlan_q.finalAtDone) begin
        storeState = fill_state(1'b0, memWriteThrough, directToModified);
      end
    end else if (finishAlloc) begin
      storeWrite = 1'b1;
      storeState = fill_state(membusReadonly, memWriteThrough, directToModified);
      troWrite = 1'b1;
      troValue = membusReadonly;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fsm_q <= FSM_RESET;
    end else begin
      case (fsm_q)
        FSM_IDLE: begin
          if (accept && plan.cycle != CYC_NONE) begin
            fsm_q <= FSM_MEM;
          end
        end
        FSM_MEM: begin
          if (memDone) begin
            fsm_q <= (heldPlan_q.cycle == CYC_WRITE_THROUGH_CYCLE_WRITE_ALLOCATE_FILL) ? FSM_WRITE_ALLOCATE_FILL : FSM_IDLE;
          end
        end
        FSM_WRITE_ALLOCATE_FILL: begin
          if (memDone) begin
            fsm_q <= FSM_IDLE;
          end
        end
        default: begin
          fsm_q <= FSM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      heldPlan_q <= '0;
      heldTro_q <= TRO_RESET;
      heldIndex_q <= '0;
      heldLine_q <= 1'b0;
      heldData_q <= 1'b0;
      heldPwt_q <= 1'b0;
    end else if (accept) begin
      heldPlan_q <= plan;
      heldTro_q <= curTro;
      heldIndex_q <= reqIndex;
      heldLine_q <= reqLine;
      heldData_q <= reqData;
      heldPwt_q <= pageWritethrough;
    end
  end

  // Memory bus cycle requests stand until memDone
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readThroughCycle_q <= 1'b0;
      writeThroughCycle_q <= 1'b0;
      lineFillCycle_q <= 1'b0;
      normalReadCycle_q <= 1'b0;
      writeAllocateFill_q <= 1'b0;
      dataFromArray_q <= 1'b0;
    end else if (accept) begin
      readThroughCycle_q <= (plan.cycle == CYC_READ_THROUGH_CYCLE);
      writeThroughCycle_q <= (plan.cycle == CYC_WRITE_THROUGH_CYCLE) || (plan.cycle == CYC_WRITE_THROUGH_CYCLE_WRITE_ALLOCATE_FILL);
      lineFillCycle_q <= (plan.cycle == CYC_LINE_FILL_CYCLE);
      normalReadCycle_q <= (plan.cycle == CYC_NORMAL_READ_CYCLE);
      dataFromArray_q <= plan.fromArray;
    end else if (memDone && fsm_q == FSM_MEM) begin
      readThroughCycle_q <= 1'b0;
      writeThroughCycle_q <= 1'b0;
      lineFillCycle_q <= 1'b0;
      normalReadCycle_q <= 1'b0;
      dataFromArray_q <= 1'b0;
      // Allocation only starts once the posted write-through has finished
      writeAllocateFill_q <= (heldPlan_q.cycle == CYC_WRITE_THROUGH_CYCLE_WRITE_ALLOCATE_FILL);
    end else if (finishAlloc) begin
      writeAllocateFill_q <= 1'b0;
    end
  end

  // Processor-side answer: one pulse per request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      respValid_q <= 1'b0;
      cpuCacheAllow_q <= 1'b1;
      cpuWritebackSelect_q <= 1'b0;
      sramUpdate_q <= 1'b0;
    end else if (accept && plan.cycle == CYC_NONE) begin
      respValid_q <= 1'b1;
      // Read-only data sectors must stay out of the first-level data cache
      cpuCacheAllow_q <= plan.cacheAllow & ~(curTro & reqData & ~reqWrite & ~reqLock);
      cpuWritebackSelect_q <= plan.writeback;
      sramUpdate_q <= plan.sramUpdate;
    end else if (fsm_q == FSM_MEM && memDone) begin
      respValid_q <= 1'b1;
      cpuCacheAllow_q <= heldPlan_q.cacheAllow;
      if (heldPlan_q.cycle == CYC_LINE_FILL_CYCLE) begin
        cpuCacheAllow_q <= ~(membusReadonly & heldData_q);
      end
      cpuWritebackSelect_q <= heldPlan_q.writeback;
      sramUpdate_q <= heldPlan_q.sramUpdate;
    end else begin
      respValid_q <= 1'b0;
      sramUpdate_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reqReady_q <= 1'b1;
    end else if (accept && plan.cycle != CYC_NONE) begin
      reqReady_q <= 1'b0;
    end else if (finishMem || finishAlloc) begin
      reqReady_q <= 1'b1;
    end
  end

  // Observation copy of the last state written
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lineStateOut_q <= LINE_STATE_RESET;
      tagReadonlyOut_q <= TRO_RESET;
    end else if (storeWrite) begin
      lineStateOut_q <= storeState;
      if (troWrite) begin
        tagReadonlyOut_q <= troValue;
      end else begin
        // Memory cycles report the tag bit seen when the request was taken
        tagReadonlyOut_q <= (fsm_q == FSM_IDLE) ? curTro : heldTro_q;
      end
    end
  end

  assign reqReady = reqReady_q;
  assign respValid = respValid_q;
  assign cpuCacheAllow = cpuCacheAllow_q;
  assign cpuWritebackSelect = cpuWritebackSelect_q;
  assign sramUpdate = sramUpdate_q;
  assign dataFromArray = dataFromArray_q;
  assign readThroughCycle = readThroughCycle_q;
  assign writeThroughCycle = writeThroughCycle_q;
  assign lineFillCycle = lineFillCycle_q;
  assign normalReadCycle = normalReadCycle_q;
  assign writeAllocateFill = writeAllocateFill_q;
  assign lineStateOut = lineStateOut_q;
  assign tagReadonlyOut = tagReadonlyOut_q;
endmodule

// ### core/lmsu_pkg.sv
// Constants and types shared by the MESI line-state update logic
package lmsu_pkg;
  localparam int unsigned SECTOR_INDEX_W = 4;
  localparam int unsigned SECTOR_COUNT = 16;
  localparam int unsigned LINES_PER_SECTOR = 2;

  typedef enum logic [1:0] {
    MESI_I = 2'b00,
    MESI_S = 2'b01,
    MESI_E = 2'b10,
    MESI_M = 2'b11
  } lmsu_mesi_type;

  typedef enum logic [2:0] {
    CYC_NONE = 3'b000,
    CYC_READ_THROUGH_CYCLE = 3'b001,
    CYC_WRITE_THROUGH_CYCLE = 3'b010,
    CYC_LINE_FILL_CYCLE = 3'b011,
    CYC_NORMAL_READ_CYCLE = 3'b100,
    CYC_WRITE_THROUGH_CYCLE_WRITE_ALLOCATE_FILL = 3'b101
  } lmsu_cycle_type;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'b00,
    FSM_MEM = 2'b01,
    FSM_WRITE_ALLOCATE_FILL = 2'b10
  } lmsu_fsm_type;

  typedef struct packed {
    lmsu_cycle_type cycle;
    lmsu_mesi_type nextState;
    logic cacheAllow;
    logic writeback;
    logic sramUpdate;
    logic fromArray;
    logic finalAtDone;
  } lmsu_plan_type;

  localparam lmsu_mesi_type LINE_STATE_RESET = MESI_I;
  localparam logic TRO_RESET = 1'b0;
  localparam lmsu_fsm_type FSM_RESET = FSM_IDLE;
endpackage

// ### core/lmsu_sector_store.sv
// Line state and read-only tag bit storage, one tag bit per sector
`timescale 1ns/1ps
module lmsu_sector_store
  import lmsu_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [SECTOR_INDEX_W-1:0] rdIndex,
  input wire logic rdLine,
  output lmsu_mesi_type rdState,
  output logic rdTro,
  input wire logic wrEnable,
  input wire logic [SECTOR_INDEX_W-1:0] wrIndex,
  input wire logic wrLine,
  input wire lmsu_mesi_type wrState,
  input wire logic troWrEnable,
  input wire logic troValue
);
  lmsu_mesi_type lineState_q [SECTOR_COUNT][LINES_PER_SECTOR];
  logic tro_q [SECTOR_COUNT];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int s = 0; s < SECTOR_COUNT; s++) begin
        for (int l = 0; l < LINES_PER_SECTOR; l++) begin
          lineState_q[s][l] <= LINE_STATE_RESET;
        end
      end
    end else if (wrEnable) begin
      lineState_q[wrIndex][wrLine] <= wrState;
    end
  end

  // One bit per sector; a line of the sector reads as read-only only while it is in state S
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int s = 0; s < SECTOR_COUNT; s++) begin
        tro_q[s] <= TRO_RESET;
      end
    end else if (troWrEnable) begin
      tro_q[wrIndex] <= troValue;
    end
  end

  assign rdState = lineState_q[rdIndex][rdLine];
  assign rdTro = tro_q[rdIndex] & (lineState_q[rdIndex][rdLine] == MESI_S);
endmodule

// ### bench/lmsu_chk.sv
// Port-level assertions for the MESI line-state update block
`timescale 1ns/1ps
module lmsu_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqData,
  input wire logic pageWritethrough,
  input wire logic memDone,
  input wire logic membusWritebackNWt,
  input wire logic membusReadonly,
  input wire logic directToModified,
  input wire logic reqReady,
  input wire logic respValid,
  input wire logic cpuCacheAllow,
  input wire logic cpuWritebackSelect,
  input wire logic sramUpdate,
  input wire logic dataFromArray,
  input wire logic readThroughCycle,
  input wire logic writeThroughCycle,
  input wire logic lineFillCycle,
  input wire logic normalReadCycle,
  input wire logic writeAllocateFill,
  input wire logic [1:0] lineStateOut,
  input wire logic tagReadonlyOut
);
  logic writeQ;
  logic pwtQ;
  logic dataQ;
  logic [4:0] cyc;
  assign cyc = {readThroughCycle, writeThroughCycle, lineFillCycle, normalReadCycle,
    writeAllocateFill};
  // Request attributes are gone from the pins by the time the answer comes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      writeQ <= 1'b0;
      pwtQ <= 1'b0;
      dataQ <= 1'b0;
    end else if (reqValid && reqReady) begin
      writeQ <= reqWrite;
      pwtQ <= pageWritethrough;
      dataQ <= reqData;
    end
  end
  function automatic logic [1:0] fillSt(logic ro, logic wt, logic dtm);
    return ro ? 2'h1 : (wt ? 2'h1 : (dtm ? 2'h3 : 2'h2));
  endfunction
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_single;
    $onehot0(cyc) && (cyc == 5'h00 || !reqReady);
  endproperty
  a_single: assert property (p_single) else $error("Memory cycles overlap");
  property p_answer;
    memDone && cyc != 5'h00 && !writeAllocateFill |=> respValid;
  endproperty
  a_answer: assert property (p_answer) else $error("No answer after memDone");
  property p_fill;
    $fell(lineFillCycle) |-> $past(memDone) && respValid && !cpuWritebackSelect
      && lineStateOut == fillSt($past(membusReadonly), pwtQ || !$past(membusWritebackNWt),
      $past(directToModified)) && tagReadonlyOut == $past(membusReadonly)
      && cpuCacheAllow == !($past(membusReadonly) && dataQ);
  endproperty
  a_fill: assert property (p_fill) else $error("Bad line fill result");
  property p_write_allocate_fill_start;
    $rose(writeAllocateFill) |-> $past(writeThroughCycle) && $past(memDone) && respValid
      && !sramUpdate;
  endproperty
  a_write_allocate_fill_start: assert property (p_write_allocate_fill_start) else $error("Bad allocation start");
  property p_write_allocate_fill_end;
    $fell(writeAllocateFill) |-> $past(memDone) && reqReady && !respValid
      && lineStateOut == fillSt($past(membusReadonly), !$past(membusWritebackNWt),
      $past(directToModified)) && tagReadonlyOut == $past(membusReadonly);
  endproperty
  a_write_allocate_fill_end: assert property (p_write_allocate_fill_end) else $error("Bad allocation state");
  property p_uncached;
    $fell(normalReadCycle) || $fell(readThroughCycle) |-> respValid && !cpuCacheAllow
      && !sramUpdate;
  endproperty
  a_uncached: assert property (p_uncached) else $error("Caching allowed on uncached read");
  property p_array;
    dataFromArray |-> readThroughCycle && !writeQ;
  endproperty
  a_array: assert property (p_array) else $error("Array data outside read-through");
  property p_read_quiet;
    respValid && !writeQ |-> !sramUpdate && (!cpuWritebackSelect || lineStateOut == 2'h3);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("Bad read answer");
  property p_sram;
    sramUpdate |-> respValid && writeQ && lineStateOut != 2'h0;
  endproperty
  a_sram: assert property (p_sram) else $error("Stray SRAM update");
endmodule

// ### bench/lmsu_membus_model.sv
// Memory bus controller model ending each memory cycle of the block
`timescale 1ns/1ps
module lmsu_membus_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [4:0] cycles,
  input wire logic [1:0] delay,
  input wire logic roCfg,
  input wire logic wbCfg,
  input wire logic dtmCfg,
  output logic memDone,
  output logic membusWritebackNWt,
  output logic membusReadonly,
  output logic directToModified
);
  logic [4:0] prevQ;
  logic [1:0] waitQ;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prevQ <= 5'h00;
      waitQ <= 2'h0;
      memDone <= 1'b0;
    end else begin
      prevQ <= cycles;
      memDone <= 1'b0;
      if (cycles == 5'h00 || cycles != prevQ) begin
        waitQ <= 2'h0;
      end else if (!memDone && waitQ == delay) begin
        memDone <= 1'b1;
      end else if (!memDone) begin
        waitQ <= waitQ + 2'h1;
      end
    end
  end
  // Attributes are only valid with memDone; elsewhere show the inverse to catch early sampling
  assign membusReadonly = memDone ? roCfg : ~roCfg;
  assign membusWritebackNWt = memDone ? wbCfg : ~wbCfg;
  assign directToModified = memDone ? dtmCfg : ~dtmCfg;
endmodule

// ### bench/lmsu_line_state_update_tb_top.sv
// Random self-checking bench for the MESI line-state update block
`timescale 1ns/1ps
`define CHECK(got, exp) begin numChecks++; if ((got) !== (exp)) begin errorCnt++; $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module lmsu_line_state_update_tb_top import lmsu_pkg::*; ;
  logic clock, resetn, reqValid, reqWrite, reqLine, reqData, reqLock, splitAccess;
  logic pageWritethrough, pageUncacheable, membusCacheable, roCfg, wbCfg, dtmCfg;
  logic [3:0] reqIndex;
  logic [1:0] delayCfg;
  logic memDone, membusWritebackNWt, membusReadonly, directToModified;
  logic reqReady, respValid, cpuCacheAllow, cpuWritebackSelect, sramUpdate, dataFromArray;
  logic readThroughCycle, writeThroughCycle, lineFillCycle, normalReadCycle, writeAllocateFill;
  logic [1:0] lineStateOut;
  logic tagReadonlyOut;
  logic [5:0] cycNow, acc;
  logic [8:0] expQ[$];
  logic [8:0] expV;
  lmsu_mesi_type st[32];
  logic troRef[16];
  int errorCnt = 0;
  int numChecks = 0;
  assign cycNow = {dataFromArray, readThroughCycle, writeThroughCycle, lineFillCycle,
    normalReadCycle, writeAllocateFill};
  lmsu_line_state_update dut_u (.clock, .resetn, .reqValid, .reqWrite, .reqIndex, .reqLine,
    .reqData, .reqLock, .splitAccess, .pageWritethrough, .pageUncacheable, .membusCacheable,
    .memDone, .membusWritebackNWt, .membusReadonly, .directToModified, .reqReady, .respValid,
    .cpuCacheAllow, .cpuWritebackSelect, .sramUpdate, .dataFromArray, .readThroughCycle,
    .writeThroughCycle, .lineFillCycle, .normalReadCycle, .writeAllocateFill, .lineStateOut,
    .tagReadonlyOut);
  lmsu_membus_model mbc_u (.clock, .resetn, .cycles(cycNow[4:0]), .delay(delayCfg), .roCfg,
    .wbCfg, .dtmCfg, .memDone, .membusWritebackNWt, .membusReadonly, .directToModified);
  function automatic lmsu_mesi_type fillSt(logic ro, logic wt);
    return ro ? MESI_S : ((wt || !wbCfg) ? MESI_S : (dtmCfg ? MESI_M : MESI_E));
  endfunction
  task automatic wrapUp();
    $display("Checks %0d, errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Expected answer bits: {array, read_through_cycle, write_through_cycle, fill, nrm, write_allocate_fill, allow, writeback, sram}
  task automatic runOp();
    logic [5:0] cyc;
    logic allow, wbs, sram, sa, tag_readonly_bit, chk;
    lmsu_mesi_type cur, nxt;
    int i;
    cur = st[{reqIndex, reqLine}];
    tag_readonly_bit = troRef[reqIndex] && cur == MESI_S;
    sa = reqLock && splitAccess;
    {cyc, allow, wbs, sram, chk, nxt, i} = {6'h00, 4'h9, cur, 0};
    if (!reqWrite) begin
      case (cur)
        MESI_M: if (sa) {cyc, allow} = 7'h60; else wbs = 1'b1;
        MESI_E: if (sa) {cyc, allow} = 7'h20;
        MESI_S: if (reqLock) {cyc, allow} = 7'h20; else if (tag_readonly_bit) allow = !reqData;
        default: begin
          if (pageUncacheable || !membusCacheable || sa) begin
            {cyc, allow, chk} = 8'h08;
          end else begin
            cyc = 6'h04;
            nxt = fillSt(roCfg, pageWritethrough);
            allow = !(roCfg && reqData);
          end
        end
      endcase
    end else begin
      case (cur)
        MESI_M: {cyc, wbs, sram} = {sa ? 6'h08 : 6'h00, 2'h3};
        MESI_E: {cyc, wbs, sram, nxt} = sa ? {6'h08, 2'h1, MESI_E} : {6'h00, 2'h3, MESI_M};
        MESI_S: begin
          {cyc, sram} = {6'h08, !tag_readonly_bit};
          if (!tag_readonly_bit) nxt = fillSt(1'b0, pageWritethrough || sa);
        end
        default: begin
          {cyc, chk} = 7'h10;
          if (!(pageUncacheable || !membusCacheable || pageWritethrough || reqLock)) begin
            {cyc, chk, nxt} = {6'h09, 1'b1, fillSt(roCfg, 1'b0)};
          end
        end
      endcase
    end
    if (cyc[2] || cyc[0]) troRef[reqIndex] = roCfg;
    st[{reqIndex, reqLine}] = nxt;
    expQ.push_back({cyc, allow, wbs, sram});
    reqValid = 1'b1;
    @(posedge clock);
    #1;
    // Hits keep the strobe up so the next request follows without a second write
    if (!reqReady) begin
      reqValid = 1'b0;
    end
    while (!reqReady && i < 200) begin
      @(posedge clock);
      #1;
      i++;
    end
    if (chk) begin
      `CHECK(lineStateOut, nxt)
      `CHECK(tagReadonlyOut, (cyc[2] || cyc[0]) ? roCfg : tag_readonly_bit)
    end
  endtask
  // Answers are matched in request order, so back-to-back hits stay paired
  always @(posedge clock) begin
    if (respValid) begin
      if (expQ.size() > 0) begin
        expV = expQ.pop_front();
        `CHECK({acc | cycNow, cpuCacheAllow, cpuWritebackSelect, sramUpdate}, expV)
      end else begin
        `CHECK(respValid, 1'b0)
      end
    end
    acc = (reqValid && reqReady) ? 6'h00 : (acc | cycNow);
  end
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #400000;
    errorCnt++;
    wrapUp();
  end
  initial begin
    {resetn, reqValid, reqWrite, reqLine, reqData, reqLock, splitAccess} = 7'h00;
    {pageWritethrough, pageUncacheable, membusCacheable, reqIndex, acc} = 13'h000;
    {roCfg, wbCfg, dtmCfg, delayCfg} = 5'h08;
    foreach (st[k]) st[k] = MESI_I;
    foreach (troRef[k]) troRef[k] = 1'b0;
    void'($urandom(80));
    repeat (8) @(posedge clock);
    #1;
    resetn = 1'b1;
    `CHECK({reqReady, cpuCacheAllow, respValid, lineStateOut, tagReadonlyOut}, 6'h30)
    repeat (700) begin
      {reqWrite, reqLine, reqData, reqLock, splitAccess} = 5'($urandom);
      {pageWritethrough, pageUncacheable} = 2'($urandom_range(3) == 0 ? 3 : $urandom_range(2));
      membusCacheable = $urandom_range(3) != 0;
      reqIndex = 4'($urandom_range(3));
      {roCfg, wbCfg, dtmCfg, delayCfg} = 5'($urandom);
      runOp();
    end
    reqValid = 1'b0;
    repeat (4) @(posedge clock);
    `CHECK(expQ.size(), 0)
    wrapUp();
  end
endmodule
bind lmsu_line_state_update lmsu_chk chk_u (.clock, .resetn, .reqValid, .reqWrite, .reqData,
  .pageWritethrough, .memDone, .membusWritebackNWt, .membusReadonly, .directToModified,
  .reqReady, .respValid, .cpuCacheAllow, .cpuWritebackSelect, .sramUpdate, .dataFromArray,
  .readThroughCycle, .writeThroughCycle, .lineFillCycle, .normalReadCycle, .writeAllocateFill,
  .lineStateOut, .tagReadonlyOut);
